// >>> lapc_bellows.sv
// Behavioural bellows and pressure sensor facing the valve outputs.
`timescale 1ns/10ps
`default_nettype none
module lapc_bellows
  import lapc_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic [`LAPC_PW-1:0] load_i,
  input  wire logic                slow_i,
  input  wire logic                lead_vent_i,
  output var  logic [`LAPC_PW-1:0] pressure_o
);
  // ****************************************************************
  // Sensor
  // ****************************************************************
  // A slow exhaust keeps the reading up while vented, so a lockout can be
  // held on pressure alone; the ignition releases it for one program cycle only.
  initial pressure_o = '0;
  always @(posedge clk_i) begin
    if (lead_vent_i && !slow_i) begin
      pressure_o <= '0;
    end else begin
      pressure_o <= load_i;
    end
  end
endmodule // lapc_bellows
`default_nettype wire

// >>> lapc_pkg.sv
// Types shared by the lifting axle pressure control block.
package lapc_pkg;
  `include "lapc_regs.svh"

  typedef enum logic [1:0] {
    LAPC_TH_IDLE    = 2'b00,
    LAPC_TH_VENT    = 2'b01,
    LAPC_TH_HOLD    = 2'b10,
    LAPC_TH_RESTORE = 2'b11
  } lapc_th_e;

  typedef struct packed {
    logic [`LAPC_PW-1:0] lower;
    logic [`LAPC_PW-1:0] raise;
    logic [`LAPC_PW-1:0] overload;
    logic [`LAPC_PW-1:0] th_limit;
    logic [`LAPC_PW-1:0] th_hyst;
    logic [`LAPC_SW-1:0] th_speed;
  } lapc_cfg_s;

  typedef struct packed {
    logic lead_vent;
    logic lift_vent;
    logic lift_fill;
    logic axle_raise;
  } lapc_valve_s;
endpackage : lapc_pkg

// >>> lapc_regs.svh
// Register map, field layout and timing constants of the lifting axle block.
// How it works
// - One leading-axle pressure decides axle position.
// - Rising load lowers axle at lowering threshold.
// - Overload threshold vents all grounded axle bellows.
// - No refill until pressure below overload; an ignition off-then-on stops venting for one program cycle even at overload.
// - Ignition off-then-on clears overload lockout.
// - Falling load raises axle at raising threshold.
// - Traction help accepted only with axle down.
// - Traction help vents lifting-axle supporting bellows.
// - At limiting pressure stop venting, hold pressure.
// - Deactivation restores pre-activation bellows pressure.
// - Traction help only below limiting speed.
// - Hysteresis band applies only below limit.
// - Limit, band, speed and times are stored.
`ifndef LAPC_REGS_SVH
`define LAPC_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define LAPC_OFS_CTRL      8'h00
`define LAPC_OFS_LOWER     8'h04
`define LAPC_OFS_RAISE     8'h08
`define LAPC_OFS_OVERLOAD  8'h0c
`define LAPC_OFS_TH_LIMIT  8'h10
`define LAPC_OFS_TH_HYST   8'h14
`define LAPC_OFS_TH_SPEED  8'h18
`define LAPC_OFS_ACT_TIME  8'h1c
`define LAPC_OFS_ACT_GAP   8'h20
`define LAPC_OFS_STATUS    8'h24
`define LAPC_OFS_PRESSURE  8'h28
`define LAPC_OFS_IRQ_STAT  8'h2c
`define LAPC_OFS_IRQ_CLR   8'h30
`define LAPC_OFS_IRQ_EN    8'h34

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define LAPC_CTRL_EN_BIT   0
`define LAPC_PW            12
`define LAPC_SW            8
`define LAPC_NIRQ          4
`define LAPC_IRQ_LOWERED   0
`define LAPC_IRQ_RAISED    1
`define LAPC_IRQ_OVERLOAD  2
`define LAPC_IRQ_TH_LIMIT  3
`define LAPC_RST_LOWER     12'hbb8
`define LAPC_RST_RAISE     12'h708
`define LAPC_RST_OVERLOAD  12'hfa0
`define LAPC_RST_TH_LIMIT  12'hee4
`define LAPC_RST_TH_HYST   12'h064
`define LAPC_RST_TH_SPEED  8'h1e
`define LAPC_RST_ACT       16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define LAPC_CLK_HZ        20000000
`define LAPC_CYCLE_US      25000
`define LAPC_CYCLE_CLKS    ((`LAPC_CYCLE_US / 1000) * (`LAPC_CLK_HZ / 1000))

`endif

// >>> lapc_sync.sv
// Two-stage synchroniser for pin inputs.
`timescale 1ns/10ps
`default_nettype none
module lapc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] async_i,
  output var  logic [W-1:0] sync_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule // lapc_sync
`default_nettype wire

// >>> lapc_tick.sv
// Program cycle timer producing one pulse per period.
`timescale 1ns/10ps
`default_nettype none
module lapc_tick #(
  parameter int unsigned PERIOD = 500000
) (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  output var  logic tick_o
);
  logic [19:0] cnt_r;
  logic        wrap;

  assign wrap = (cnt_r == 20'(PERIOD - 1));

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_r  <= 20'h00000;
      tick_o <= 1'b0;
    end else begin
      cnt_r  <= wrap ? 20'h00000 : cnt_r + 20'h00001;
      tick_o <= wrap;
    end
  end
endmodule // lapc_tick
`default_nettype wire

// >>> lapc_top.sv
// Lifting axle pressure controller with register port and valve outputs.
//
// Chosen here: the register offsets and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module lapc_top
  import lapc_pkg::*;
#(
  parameter int unsigned CYCLE_CLKS = `LAPC_CYCLE_CLKS
) (
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  input  wire logic [7:0]          addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output var  logic [31:0]         rdata_o,
  input  wire logic [`LAPC_PW-1:0] pressure_i,
  input  wire logic [`LAPC_SW-1:0] speed_i,
  input  wire logic                ignition_i,
  input  wire logic                traction_req_i,
  output var  logic                lead_vent_o,
  output var  logic                lift_vent_o,
  output var  logic                lift_fill_o,
  output var  logic                axle_raise_o,
  output var  logic                irq_o
);

  // ****************************************************************
  // Pin synchronisation and program cycle
  // ****************************************************************
  localparam int SW = `LAPC_PW + `LAPC_SW + 2;

  logic [SW-1:0]         pin_sync;
  logic [`LAPC_PW-1:0]   p_pin;
  logic [`LAPC_SW-1:0]   v_pin;
  logic                  ign_pin;
  logic                  req_pin;
  logic                  tick;

  lapc_sync #(
    .W (SW)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i ({pressure_i, speed_i, ignition_i, traction_req_i}),
    .sync_o  (pin_sync)
  );

  assign {p_pin, v_pin, ign_pin, req_pin} = pin_sync;

  lapc_tick #(
    .PERIOD (CYCLE_CLKS)
  ) u_tick (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (tick)
  );

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  lapc_cfg_s           cfg_r;
  logic                en_r;
  logic [15:0]         act_time_r;
  logic [15:0]         act_gap_r;
  logic [`LAPC_NIRQ-1:0] irq_stat_r;
  logic [`LAPC_NIRQ-1:0] irq_en_r;

  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  wire w_ctrl  = wr_i && hit(addr_i, `LAPC_OFS_CTRL);
  wire w_low   = wr_i && hit(addr_i, `LAPC_OFS_LOWER);
  wire w_rais  = wr_i && hit(addr_i, `LAPC_OFS_RAISE);
  wire w_ovl   = wr_i && hit(addr_i, `LAPC_OFS_OVERLOAD);
  wire w_lim   = wr_i && hit(addr_i, `LAPC_OFS_TH_LIMIT);
  wire w_hyst  = wr_i && hit(addr_i, `LAPC_OFS_TH_HYST);
  wire w_spd   = wr_i && hit(addr_i, `LAPC_OFS_TH_SPEED);
  wire w_atime = wr_i && hit(addr_i, `LAPC_OFS_ACT_TIME);
  wire w_agap  = wr_i && hit(addr_i, `LAPC_OFS_ACT_GAP);
  wire w_iclr  = wr_i && hit(addr_i, `LAPC_OFS_IRQ_CLR);
  wire w_ien   = wr_i && hit(addr_i, `LAPC_OFS_IRQ_EN);

  wire [`LAPC_PW-1:0] wd_p = wdata_i[`LAPC_PW-1:0];

  // Thresholds are taken as written; ordering them is software's job.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      en_r           <= 1'b0;
      cfg_r.lower    <= `LAPC_RST_LOWER;
      cfg_r.raise    <= `LAPC_RST_RAISE;
      cfg_r.overload <= `LAPC_RST_OVERLOAD;
      cfg_r.th_limit <= `LAPC_RST_TH_LIMIT;
      cfg_r.th_hyst  <= `LAPC_RST_TH_HYST;
      cfg_r.th_speed <= `LAPC_RST_TH_SPEED;
      act_time_r     <= `LAPC_RST_ACT;
      act_gap_r      <= `LAPC_RST_ACT;
      irq_en_r       <= '0;
    end else begin
      if (w_ctrl)  en_r           <= wdata_i[`LAPC_CTRL_EN_BIT];
      if (w_low)   cfg_r.lower    <= wd_p;
      if (w_rais)  cfg_r.raise    <= wd_p;
      if (w_ovl)   cfg_r.overload <= wd_p;
      if (w_lim)   cfg_r.th_limit <= wd_p;
      if (w_hyst)  cfg_r.th_hyst  <= wd_p;
      if (w_spd)   cfg_r.th_speed <= wdata_i[`LAPC_SW-1:0];
      if (w_atime) act_time_r     <= wdata_i[15:0];
      if (w_agap)  act_gap_r      <= wdata_i[15:0];
      if (w_ien)   irq_en_r       <= wdata_i[`LAPC_NIRQ-1:0];
    end
  end

  // ****************************************************************
  // Per-cycle sampling and comparisons
  // ****************************************************************
  logic [`LAPC_PW-1:0] p_r;
  logic                ign_r;
  logic                ign_prev_r;
  logic                req_r;
  logic                slow_r;

  // All decisions use values frozen at the cycle tick so that one
  // program cycle sees a single consistent pressure.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      p_r        <= '0;
      ign_r      <= 1'b1;
      ign_prev_r <= 1'b1;
      req_r      <= 1'b0;
      slow_r     <= 1'b0;
    end else if (tick) begin
      p_r        <= p_pin;
      ign_prev_r <= ign_r;
      ign_r      <= ign_pin;
      req_r      <= req_pin;
      slow_r     <= (v_pin < cfg_r.th_speed);
    end
  end

  logic eval_r;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      eval_r <= 1'b0;
    end else begin
      eval_r <= tick;
    end
  end

  wire ge_lower = (p_r >= cfg_r.lower);
  wire le_raise = (p_r <= cfg_r.raise);
  wire ge_ovl   = (p_r >= cfg_r.overload);
  wire ge_lim   = (p_r >= cfg_r.th_limit);
  wire [`LAPC_PW:0] band_lo = {1'b0, cfg_r.th_limit}
                            - {1'b0, cfg_r.th_hyst};
  // The band runs from th_hyst below the limit upward; a band wider than the limit is empty.
  wire in_band  = !band_lo[`LAPC_PW]
                  && (p_r >= band_lo[`LAPC_PW-1:0]);
  wire ign_on   = ign_r && !ign_prev_r;

  // ****************************************************************
  // Overload lockout and axle position
  // ****************************************************************
  logic                axle_up_r;
  logic                ovl_lock_r;
  logic                axle_up_nxt;
  logic                ovl_lock_nxt;
  lapc_th_e            th_st_r;
  lapc_th_e            th_st_nxt;
  logic [`LAPC_PW-1:0] p_pre_r;

  // The ignition cycle wins for one program cycle so the bellows refill;
  // a pressure still at overload locks again on the next cycle.
  always_comb begin
    ovl_lock_nxt = ovl_lock_r;
    if (ign_on) begin
      ovl_lock_nxt = 1'b0;
    end else if (ge_ovl) begin
      ovl_lock_nxt = 1'b1;
    end else begin
      ovl_lock_nxt = 1'b0;
    end
  end

  always_comb begin
    axle_up_nxt = axle_up_r;
    if (axle_up_r && ge_lower) begin
      axle_up_nxt = 1'b0;
    end else if (!axle_up_r && le_raise) begin
      axle_up_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      axle_up_r  <= 1'b1;
      ovl_lock_r <= 1'b0;
    end else if (eval_r && en_r) begin
      ovl_lock_r <= ovl_lock_nxt;
      if (th_st_r == LAPC_TH_IDLE) begin
        axle_up_r <= axle_up_nxt;
      end
    end
  end

  // ****************************************************************
  // Traction help
  // ****************************************************************
  // Pressure must be in the down-axle region with no lockout and the
  // vehicle slow before a request is honoured.
  wire th_ok = req_r && !axle_up_r && !ovl_lock_r
               && slow_r && !ge_ovl;

  always_comb begin
    th_st_nxt = th_st_r;
    case (th_st_r)
      LAPC_TH_IDLE: begin
        if (th_ok && !ge_lim) begin
          th_st_nxt = LAPC_TH_VENT;
        end
      end
      LAPC_TH_VENT: begin
        if (!th_ok) begin
          th_st_nxt = LAPC_TH_RESTORE;
        end else if (ge_lim) begin
          th_st_nxt = LAPC_TH_HOLD;
        end
      end
      LAPC_TH_HOLD: begin
        if (!th_ok) begin
          th_st_nxt = LAPC_TH_RESTORE;
        end else if (!in_band && !ge_lim) begin
          th_st_nxt = LAPC_TH_VENT;
        end
      end
      LAPC_TH_RESTORE: begin
        if (p_r <= p_pre_r) begin
          th_st_nxt = LAPC_TH_IDLE;
        end
      end
      default: begin
        th_st_nxt = LAPC_TH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      th_st_r <= LAPC_TH_IDLE;
      p_pre_r <= '0;
    end else if (eval_r && en_r) begin
      th_st_r <= th_st_nxt;
      if (th_st_r == LAPC_TH_IDLE) begin
        p_pre_r <= p_r;
      end
    end
  end

  // ****************************************************************
  // Valve outputs
  // ****************************************************************
  lapc_valve_s valve_nxt;

  // Overload venting overrides everything else; the lifting axle
  // itself is not raised by it, only the grounded bellows dump.
  always_comb begin
    valve_nxt            = '0;
    valve_nxt.axle_raise = axle_up_r;
    if (ovl_lock_r) begin
      valve_nxt.lead_vent = 1'b1;
      valve_nxt.lift_vent = !axle_up_r;
    end else begin
      case (th_st_r)
        LAPC_TH_VENT:    valve_nxt.lift_vent = 1'b1;
        LAPC_TH_HOLD:    valve_nxt.lift_fill = ge_lim;
        LAPC_TH_RESTORE: valve_nxt.lift_fill = 1'b1;
        default:         valve_nxt.lift_vent = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lead_vent_o  <= 1'b0;
      lift_vent_o  <= 1'b0;
      lift_fill_o  <= 1'b0;
      axle_raise_o <= 1'b0;
    end else if (eval_r) begin
      lead_vent_o  <= en_r & valve_nxt.lead_vent;
      lift_vent_o  <= en_r & valve_nxt.lift_vent;
      lift_fill_o  <= en_r & valve_nxt.lift_fill;
      axle_raise_o <= en_r & valve_nxt.axle_raise;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  logic [`LAPC_NIRQ-1:0] ev;
  logic [`LAPC_NIRQ-1:0] clr;

  wire upd = eval_r && en_r;

  assign ev[`LAPC_IRQ_LOWERED]  = upd && (th_st_r == LAPC_TH_IDLE)
                                  && axle_up_r && !axle_up_nxt;
  assign ev[`LAPC_IRQ_RAISED]   = upd && (th_st_r == LAPC_TH_IDLE)
                                  && !axle_up_r && axle_up_nxt;
  assign ev[`LAPC_IRQ_OVERLOAD] = upd && ovl_lock_nxt && !ovl_lock_r;
  assign ev[`LAPC_IRQ_TH_LIMIT] = upd && (th_st_nxt == LAPC_TH_HOLD)
                                  && (th_st_r == LAPC_TH_VENT);
  assign clr = w_iclr ? wdata_i[`LAPC_NIRQ-1:0] : '0;

  // A new event beats a clear that lands in the same cycle.
  genvar gi;
  generate
    for (gi = 0; gi < `LAPC_NIRQ; gi++) begin : g_irq
      always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
          irq_stat_r[gi] <= 1'b0;
        end else if (ev[gi]) begin
          irq_stat_r[gi] <= 1'b1;
        end else if (clr[gi]) begin
          irq_stat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_en_r);
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************
  logic [31:0] rd_mux;

  wire [31:0] status_w = {26'h0000000, th_st_r, slow_r,
                          ign_r, ovl_lock_r, axle_up_r};

  always_comb begin
    case (addr_i)
      `LAPC_OFS_CTRL:     rd_mux = {31'h00000000, en_r};
      `LAPC_OFS_LOWER:    rd_mux = {20'h00000, cfg_r.lower};
      `LAPC_OFS_RAISE:    rd_mux = {20'h00000, cfg_r.raise};
      `LAPC_OFS_OVERLOAD: rd_mux = {20'h00000, cfg_r.overload};
      `LAPC_OFS_TH_LIMIT: rd_mux = {20'h00000, cfg_r.th_limit};
      `LAPC_OFS_TH_HYST:  rd_mux = {20'h00000, cfg_r.th_hyst};
      `LAPC_OFS_TH_SPEED: rd_mux = {24'h000000, cfg_r.th_speed};
      `LAPC_OFS_ACT_TIME: rd_mux = {16'h0000, act_time_r};
      `LAPC_OFS_ACT_GAP:  rd_mux = {16'h0000, act_gap_r};
      `LAPC_OFS_STATUS:   rd_mux = status_w;
      `LAPC_OFS_PRESSURE: rd_mux = {20'h00000, p_r};
      `LAPC_OFS_IRQ_STAT: rd_mux = {28'h0000000, irq_stat_r};
      `LAPC_OFS_IRQ_EN:   rd_mux = {28'h0000000, irq_en_r};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // Data appear only in the cycle after the strobe and read zero
  // otherwise, so a stale value cannot be mistaken for an answer.
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= rd_i ? rd_mux : 32'h00000000;
    end
  end

endmodule // lapc_top
`default_nettype wire

// >>> lapc_top_sva.sv
// Concurrent checks on the ports of the lifting axle controller.
`timescale 1ns/10ps
`default_nettype none
module lapc_top_sva
  import lapc_pkg::*;
#(
  parameter int unsigned CYCLE_CLKS = 20
) (
  input wire logic                clk_i,
  input wire logic                rst_b_i,
  input wire logic [7:0]          addr_i,
  input wire logic [31:0]         wdata_i,
  input wire logic                wr_i,
  input wire logic                rd_i,
  input wire logic [31:0]         rdata_o,
  input wire logic [`LAPC_SW-1:0] speed_i,
  input wire logic                lead_vent_o,
  input wire logic                lift_vent_o,
  input wire logic                lift_fill_o,
  input wire logic                axle_raise_o,
  input wire logic                irq_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  // The bench never rewrites the stored speed limit.
  localparam logic [7:0] SPEED_LIM = `LAPC_RST_TH_SPEED;
  wire logic [3:0] valves;
  assign valves = {lead_vent_o, lift_vent_o, lift_fill_o, axle_raise_o};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);

  property p_rd_idle;
    !rd_i |=> rdata_o == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");
  property p_rd_upper;
    rd_i |=> rdata_o[31:16] == 16'h0;
  endproperty
  a_rd_upper: assert property (p_rd_upper)
    else $error("upper read data bits set");
  property p_clr_read;
    rd_i && addr_i == 8'h30 |=> rdata_o == 32'h0;
  endproperty
  a_clr_read: assert property (p_clr_read)
    else $error("clear register read back nonzero");
  property p_vent_fill;
    !(lift_vent_o && lift_fill_o);
  endproperty
  a_vent_fill: assert property (p_vent_fill)
    else $error("lift bellows vented and filled together");
  property p_ovl_nofill;
    lead_vent_o |-> !lift_fill_o;
  endproperty
  a_ovl_nofill: assert property (p_ovl_nofill)
    else $error("refill during overload venting");
  property p_hold;
    $changed(valves) |=> $stable(valves) [*8];
  endproperty
  a_hold: assert property (p_hold)
    else $error("valve outputs changed within a program cycle");
  property p_speed;
    $rose(lift_vent_o) && !lead_vent_o |-> $past(speed_i, 24) < SPEED_LIM;
  endproperty
  a_speed: assert property (p_speed)
    else $error("traction venting at or above the limiting speed");
  property p_trac_down;
    lift_vent_o && !lead_vent_o |-> !axle_raise_o;
  endproperty
  a_trac_down: assert property (p_trac_down)
    else $error("traction venting with the axle up");
  property p_irq_mask;
    wr_i && addr_i == 8'h34 && wdata_i[3:0] == 4'h0 |-> ##3 !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt high with all enables cleared");

  c_lower: cover property ($fell(axle_raise_o));
  c_ovl: cover property ($rose(lead_vent_o));
  c_trac: cover property ($rose(lift_vent_o) && !lead_vent_o);
  c_restore: cover property ($rose(lift_fill_o));
endmodule // lapc_top_sva

bind lapc_top lapc_top_sva #(.CYCLE_CLKS(CYCLE_CLKS)) u_sva (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .speed_i(speed_i),
  .lead_vent_o(lead_vent_o), .lift_vent_o(lift_vent_o),
  .lift_fill_o(lift_fill_o), .axle_raise_o(axle_raise_o), .irq_o(irq_o)
);
`default_nettype wire

// >>> test_lifting_axle_pressure_control.sv
// Self-checking bench for the lifting axle controller.
`timescale 1ns/10ps
`default_nettype none
module test_lifting_axle_pressure_control;
  import lapc_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int unsigned CYC = 20;
  localparam logic [7:0]  RA [6] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  localparam logic [31:0] RV [6] = '{32'hbb8, 32'h708, 32'hfa0, 32'hee4,
                                     32'h064, 32'h01e};
  logic        clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        ign = 1'b1;
  logic        trq = 1'b0;
  logic        slow = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [7:0]  spd = 8'h0a;
  logic [31:0] wdata_i = 32'h0;
  logic [11:0] load = 12'h100;
  wire logic [31:0] rdata_o;
  wire logic [11:0] pres;
  wire logic        lead, lvent, lfill, lraise, irq;
  wire logic [3:0]  vv;
  int errors = 0;
  int n_compared = 0;
  assign vv = {lead, lvent, lfill, lraise};

  lapc_top #(.CYCLE_CLKS(CYC)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pressure_i(pres),
    .speed_i(spd), .ignition_i(ign), .traction_req_i(trq),
    .lead_vent_o(lead), .lift_vent_o(lvent), .lift_fill_o(lfill),
    .axle_raise_o(lraise), .irq_o(irq)
  );
  lapc_bellows u_bellows (
    .clk_i(clk_i), .load_i(load), .slow_i(slow), .lead_vent_i(lead),
    .pressure_o(pres)
  );

  initial begin
    forever #25 clk_i = ~clk_i;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic set_pins(input logic [7:0] s, input logic t,
                          input logic g);
    @(posedge clk_i);
    spd <= s;
    trq <= t;
    ign <= g;
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(exp, rdata_o);
  endtask
  // Outputs lag the sampled pressure by up to two program cycles.
  task automatic wait_v(input int i, input logic v);
    for (int k = 0; k < 6 * CYC && vv[i] !== v; k++) begin
      tick(1);
    end
    chk({31'h0, v}, {31'h0, vv[i]});
    if (vv[i] !== v) begin
      final_report();
    end
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset thresholds already keep the required order and ratios.
  task automatic t_regs;
    for (int i = 0; i < 6; i++) begin
      rd_chk(RA[i], RV[i]);
    end
    wr(8'h1c, 32'hffff1234);
    rd_chk(8'h1c, 32'h1234);
    wr(8'h28, 32'hfff);
    tick(CYC);
    rd_chk(8'h28, 32'h100);
    rd_chk(8'h3c, 32'h0);
    chk(32'h0, {28'h0, vv});
    $display("test regs done");
  endtask
  task automatic t_axle;
    wr(8'h34, 32'hf);
    wr(8'h00, 32'h1);
    wait_v(0, 1'b1);
    load <= 12'hbb8;
    wait_v(0, 1'b0);
    chk(32'h1, {31'h0, irq});
    wr(8'h30, 32'hf);
    tick(3);
    chk(32'h0, {31'h0, irq});
    load <= 12'h900;
    tick(3 * CYC);
    chk(32'h0, {31'h0, lraise});
    load <= 12'h708;
    wait_v(0, 1'b1);
    load <= 12'h900;
    tick(3 * CYC);
    chk(32'h1, {31'h0, lraise});
    load <= 12'hc00;
    wait_v(0, 1'b0);
    $display("test axle done");
  endtask
  task automatic t_trac_refused;
    set_pins(8'h1e, 1'b0, 1'b1);
    tick(2 * CYC);
    set_pins(8'h1e, 1'b1, 1'b1);
    tick(4 * CYC);
    chk(32'h0, {31'h0, lvent});
    set_pins(8'h0a, 1'b0, 1'b1);
    tick(2 * CYC);
    $display("test speed limit done");
  endtask
  task automatic t_trac;
    set_pins(8'h0a, 1'b1, 1'b1);
    wait_v(2, 1'b1);
    load <= 12'hee4;
    wait_v(2, 1'b0);
    load <= 12'hea0;
    wait_v(1, 1'b0);
    tick(3 * CYC);
    chk(32'h0, {30'h0, lvent, lfill});
    load <= 12'he00;
    wait_v(2, 1'b1);
    set_pins(8'h0a, 1'b0, 1'b1);
    wait_v(1, 1'b1);
    load <= 12'hc00;
    wait_v(1, 1'b0);
    tick(2 * CYC);
    chk(32'h0, {29'h0, lvent, lfill, lraise});
    $display("test traction done");
  endtask
  task automatic t_overload;
    slow <= 1'b1;
    load <= 12'hfa0;
    wait_v(3, 1'b1);
    chk(32'h1, {31'h0, lvent});
    tick(3 * CYC);
    chk(32'h1, {31'h0, lead});
    set_pins(8'h0a, 1'b0, 1'b0);
    tick(2 * CYC);
    set_pins(8'h0a, 1'b0, 1'b1);
    wait_v(3, 1'b0);
    slow <= 1'b0;
    wait_v(3, 1'b1);
    wait_v(3, 1'b0);
    load <= 12'h100;
    wait_v(0, 1'b1);
    wr(8'h34, 32'h0);
    tick(3);
    chk(32'h0, {31'h0, irq});
    $display("test overload done");
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_axle();
    t_trac_refused();
    t_trac();
    t_overload();
    final_report();
  end
endmodule // test_lifting_axle_pressure_control
`default_nettype wire
